// ---- core/gpb_defs.svh ----
// Register indices, reset values and bus response codes for the GPIO block
`ifndef GPB_DEFS_SVH
`define GPB_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define GPB_IDX_A_DATA 32'hFFFF_F0C0
`define GPB_IDX_B_DATA 32'hFFFF_F0C1
`define GPB_IDX_C_DATA 32'hFFFF_F0C2
`define GPB_IDX_A_DIR  32'hFFFF_F0C4
`define GPB_IDX_B_DIR  32'hFFFF_F0C5
`define GPB_IDX_C_DIR  32'hFFFF_F0C6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define GPB_LATCH_RST  8'hFF
`define GPB_DIR_RST    8'h00

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define GPB_RESP_OKAY   2'b00
`define GPB_RESP_SLVERR 2'b10

`endif

// ---- core/gpb_pkg.sv ----
// Types shared by the GPIO block
package gpb_pkg;

  typedef logic [7:0] gpb_byte_t;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    GPB_SEL_A_DATA = 3'b000,
    GPB_SEL_B_DATA = 3'b001,
    GPB_SEL_C_DATA = 3'b010,
    GPB_SEL_A_DIR  = 3'b011,
    GPB_SEL_B_DIR  = 3'b100,
    GPB_SEL_C_DIR  = 3'b101,
    GPB_SEL_NONE   = 3'b111
  } gpb_sel_e;

endpackage : gpb_pkg

// ---- core/gpb_top.sv ----
// Three 8-bit GPIO ports behind an AXI4-Lite register slave
`timescale 1ns/1ps
`include "gpb_defs.svh"

// Operation
// - Three separate 8-bit ports each own a data and a direction register, one bit per pin.
// - Each direction bit alone sets its pin: zero is input, one is output.
// - Reset clears every direction register so all pins start as inputs.
// - Reset sets every output latch bit to one so a later output drives high.
module gpb_top
(
  // Clock and reset
  input  wire logic              CORE_CLK_I,
  input  wire logic              SYS_RST_I,
  // AXI4-Lite write address and data
  input  wire logic              AWVALID_I,
  output logic                   AWREADY_O,
  input  wire logic [31:0]       AWADDR_I,
  input  wire logic              WVALID_I,
  output logic                   WREADY_O,
  input  wire logic [31:0]       WDATA_I,
  input  wire logic [3:0]        WSTRB_I,
  // AXI4-Lite write response
  output logic                   BVALID_O,
  input  wire logic              BREADY_I,
  output logic [1:0]             BRESP_O,
  // AXI4-Lite read
  input  wire logic              ARVALID_I,
  output logic                   ARREADY_O,
  input  wire logic [31:0]       ARADDR_I,
  output logic                   RVALID_O,
  input  wire logic              RREADY_I,
  output logic [31:0]            RDATA_O,
  output logic [1:0]             RRESP_O,
  // Port pins
  input  wire gpb_pkg::gpb_byte_t GPIO_A_IN_I,
  output gpb_pkg::gpb_byte_t      GPIO_A_OUT_O,
  output gpb_pkg::gpb_byte_t      GPIO_A_OE_O,
  input  wire gpb_pkg::gpb_byte_t GPIO_B_IN_I,
  output gpb_pkg::gpb_byte_t      GPIO_B_OUT_O,
  output gpb_pkg::gpb_byte_t      GPIO_B_OE_O,
  input  wire gpb_pkg::gpb_byte_t GPIO_C_IN_I,
  output gpb_pkg::gpb_byte_t      GPIO_C_OUT_O,
  output gpb_pkg::gpb_byte_t      GPIO_C_OE_O
);
  import gpb_pkg::*;

  localparam int NPORT = 3;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  // Only the index bits are compared; byte lanes above index*4 wrap.
  function automatic gpb_sel_e gpb_decode(input logic [31:0] addr);
    logic [29:0] idx;
    idx = addr[31:2];
    if (idx == 30'(`GPB_IDX_A_DATA)) return GPB_SEL_A_DATA;
    if (idx == 30'(`GPB_IDX_B_DATA)) return GPB_SEL_B_DATA;
    if (idx == 30'(`GPB_IDX_C_DATA)) return GPB_SEL_C_DATA;
    if (idx == 30'(`GPB_IDX_A_DIR))  return GPB_SEL_A_DIR;
    if (idx == 30'(`GPB_IDX_B_DIR))  return GPB_SEL_B_DIR;
    if (idx == 30'(`GPB_IDX_C_DIR))  return GPB_SEL_C_DIR;
    return GPB_SEL_NONE;
  endfunction : gpb_decode

  // --------------------------------------------------------------------
  // Port state
  // --------------------------------------------------------------------
  gpb_byte_t   lat_reg [NPORT];
  gpb_byte_t   lat_next[NPORT];
  gpb_byte_t   dir_reg [NPORT];
  gpb_byte_t   dir_next[NPORT];
  gpb_byte_t   pin_reg [NPORT];
  gpb_byte_t   pin_in  [NPORT];
  gpb_byte_t   mix     [NPORT];

  assign pin_in[0] = GPIO_A_IN_I;
  assign pin_in[1] = GPIO_B_IN_I;
  assign pin_in[2] = GPIO_C_IN_I;

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++)
    begin : g_port
      // Output bits read back the latch, input bits the pin
      assign mix[gp] = (dir_reg[gp] & lat_reg[gp]) |
                       (~dir_reg[gp] & pin_reg[gp]);
      always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
      begin
        if (SYS_RST_I)
          pin_reg[gp] <= 8'h00;
        else
          pin_reg[gp] <= pin_in[gp];
      end
    end
  endgenerate

  // Pins come straight from the registers
  assign GPIO_A_OUT_O = lat_reg[0];
  assign GPIO_B_OUT_O = lat_reg[1];
  assign GPIO_C_OUT_O = lat_reg[2];
  assign GPIO_A_OE_O  = dir_reg[0];
  assign GPIO_B_OE_O  = dir_reg[1];
  assign GPIO_C_OE_O  = dir_reg[2];

  // --------------------------------------------------------------------
  // Write channel and register update
  // --------------------------------------------------------------------
  logic        aw_full_reg, aw_full_next;
  logic        w_full_reg,  w_full_next;
  logic [31:0] awaddr_reg,  awaddr_next;
  logic [7:0]  wdata_reg,   wdata_next;
  logic        wstrb_reg,   wstrb_next;
  logic        awready_reg, awready_next;
  logic        wready_reg,  wready_next;
  logic        bvalid_reg,  bvalid_next;
  logic [1:0]  bresp_reg,   bresp_next;
  logic        do_write;
  gpb_sel_e    wsel;

  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wsel     = gpb_decode(awaddr_reg);

  always_comb
  begin
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    for (int p = 0; p < NPORT; p++)
    begin
      lat_next[p] = lat_reg[p];
      dir_next[p] = dir_reg[p];
    end
    if (bvalid_reg && BREADY_I)
      bvalid_next = 1'b0;
    if (do_write)
    begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = `GPB_RESP_OKAY;
      // Registers live in byte lane 0 only
      case (wsel)
        GPB_SEL_A_DATA: if (wstrb_reg) lat_next[0] = wdata_reg;
        GPB_SEL_B_DATA: if (wstrb_reg) lat_next[1] = wdata_reg;
        GPB_SEL_C_DATA: if (wstrb_reg) lat_next[2] = wdata_reg;
        GPB_SEL_A_DIR:  if (wstrb_reg) dir_next[0] = wdata_reg;
        GPB_SEL_B_DIR:  if (wstrb_reg) dir_next[1] = wdata_reg;
        GPB_SEL_C_DIR:  if (wstrb_reg) dir_next[2] = wdata_reg;
        default:        bresp_next = `GPB_RESP_SLVERR;
      endcase
    end
    if (AWVALID_I && awready_reg)
    begin
      aw_full_next = 1'b1;
      awaddr_next  = AWADDR_I;
    end
    if (WVALID_I && wready_reg)
    begin
      w_full_next = 1'b1;
      wdata_next  = WDATA_I[7:0];
      wstrb_next  = WSTRB_I[0];
    end
    awready_next = !aw_full_next && !bvalid_next;
    wready_next  = !w_full_next && !bvalid_next;
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= 32'h0000_0000;
      wdata_reg   <= 8'h00;
      wstrb_reg   <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `GPB_RESP_OKAY;
      for (int p = 0; p < NPORT; p++)
      begin
        lat_reg[p] <= `GPB_LATCH_RST;
        dir_reg[p] <= `GPB_DIR_RST;
      end
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      for (int p = 0; p < NPORT; p++)
      begin
        lat_reg[p] <= lat_next[p];
        dir_reg[p] <= dir_next[p];
      end
    end
  end

  assign AWREADY_O = awready_reg;
  assign WREADY_O  = wready_reg;
  assign BVALID_O  = bvalid_reg;
  assign BRESP_O   = bresp_reg;

  // --------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------
  logic        arready_reg, arready_next;
  logic        rvalid_reg,  rvalid_next;
  logic [31:0] rdata_reg,   rdata_next;
  logic [1:0]  rresp_reg,   rresp_next;
  gpb_sel_e    rsel;

  assign rsel = gpb_decode(ARADDR_I);

  always_comb
  begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (rvalid_reg && RREADY_I)
      rvalid_next = 1'b0;
    if (ARVALID_I && arready_reg)
    begin
      rvalid_next = 1'b1;
      rresp_next  = `GPB_RESP_OKAY;
      case (rsel)
        GPB_SEL_A_DATA: rdata_next = {24'h00_0000, mix[0]};
        GPB_SEL_B_DATA: rdata_next = {24'h00_0000, mix[1]};
        GPB_SEL_C_DATA: rdata_next = {24'h00_0000, mix[2]};
        GPB_SEL_A_DIR:  rdata_next = {24'h00_0000, dir_reg[0]};
        GPB_SEL_B_DIR:  rdata_next = {24'h00_0000, dir_reg[1]};
        GPB_SEL_C_DIR:  rdata_next = {24'h00_0000, dir_reg[2]};
        default:
        begin
          rdata_next = 32'h0000_0000;
          rresp_next = `GPB_RESP_SLVERR;
        end
      endcase
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `GPB_RESP_OKAY;
    end
    else
    begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign ARREADY_O = arready_reg;
  assign RVALID_O  = rvalid_reg;
  assign RDATA_O   = rdata_reg;
  assign RRESP_O   = rresp_reg;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  // Reset value seen at the edge where reset is released
  property p_dir_reset;
    @(posedge CORE_CLK_I) $fell(SYS_RST_I) |->
      ({GPIO_A_OE_O, GPIO_B_OE_O, GPIO_C_OE_O} == 24'h00_0000);
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("Direction not cleared by reset");

  property p_latch_reset;
    @(posedge CORE_CLK_I) $fell(SYS_RST_I) |->
      ({GPIO_A_OUT_O, GPIO_B_OUT_O, GPIO_C_OUT_O} == 24'hFF_FFFF);
  endproperty
  a_latch_reset: assert property (p_latch_reset)
    else $error("Output latch not set by reset");

  property p_data_write;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (do_write && wstrb_reg && wsel == GPB_SEL_B_DATA) |=>
      (GPIO_B_OUT_O == $past(wdata_reg)) && $stable(GPIO_B_OE_O);
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("Data write did not reach port B latch");

  property p_port_isolation;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (do_write && wsel == GPB_SEL_C_DIR) |=>
      $stable(GPIO_A_OE_O) && $stable(GPIO_B_OE_O) &&
      $stable(GPIO_A_OUT_O) && (GPIO_C_OE_O == $past(dir_next[2]));
  endproperty
  a_port_isolation: assert property (p_port_isolation)
    else $error("Port C direction write disturbed another port");

  property p_read_mix;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (ARVALID_I && ARREADY_O && rsel == GPB_SEL_A_DATA) |=>
      RVALID_O && RDATA_O[7:0] == (($past(GPIO_A_OE_O) &
      $past(GPIO_A_OUT_O)) | (~$past(GPIO_A_OE_O) & $past(pin_reg[0])));
  endproperty
  a_read_mix: assert property (p_read_mix)
    else $error("Port A read did not mix pins and latch by direction");

  property p_write_resp;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (aw_full_reg && w_full_reg && !bvalid_reg) |=> BVALID_O;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("Write response missing one cycle after both parts");

  c_write_dir: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    do_write && wsel == GPB_SEL_A_DIR);
  c_read_data: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    RVALID_O && RREADY_I && RRESP_O == `GPB_RESP_OKAY);
  c_bad_write: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    BVALID_O && BRESP_O == `GPB_RESP_SLVERR);

endmodule : gpb_top

// ---- dv/gpb_pins_model.sv ----
// Model of the outside circuitry wired to one 8-bit GPIO port
`timescale 1ns/1ps
module gpb_pins_model
(
  // Device side
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] oe_i,
  // Outside drive and resolved pin levels
  input  wire logic [7:0] ext_i,
  output logic      [7:0] pin_o
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // Outside circuit yields wherever the device drives, bit by bit
  always_comb
  begin
    for (int b = 0; b < 8; b++)
    begin
      pin_o[b] = oe_i[b] ? out_i[b] : ext_i[b];
    end
  end
endmodule : gpb_pins_model

// ---- dv/gpb_top_tb_top.sv ----
// Register-level testbench for the three-port GPIO block
`timescale 1ns/1ps
`include "gpb_defs.svh"
module gpb_top_tb_top;
  logic        clk = 0, rst = 1;
  logic        awv = 0, wv = 0, bv, br = 0, arv = 0, rv, rr = 0;
  logic        awr, wr_rdy, arr;
  logic [31:0] awa = 0, wd = 0, ara = 0, rd_data;
  logic [3:0]  ws = 0;
  logic [1:0]  bresp, rresp;
  logic [7:0]  p_out [3], p_oe [3], p_in [3], ext [3];
  int          n_mismatch = 0, n_compared = 0, cyc = 0;
  localparam logic [31:0] IDX [6] = '{`GPB_IDX_A_DATA, `GPB_IDX_B_DATA,
    `GPB_IDX_C_DATA, `GPB_IDX_A_DIR, `GPB_IDX_B_DIR, `GPB_IDX_C_DIR};
  always #2.5 clk = ~clk;
  gpb_top i_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .AWVALID_I(awv),
    .AWREADY_O(awr), .AWADDR_I(awa), .WVALID_I(wv), .WREADY_O(wr_rdy),
    .WDATA_I(wd), .WSTRB_I(ws), .BVALID_O(bv), .BREADY_I(br),
    .BRESP_O(bresp), .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ara),
    .RVALID_O(rv), .RREADY_I(rr), .RDATA_O(rd_data), .RRESP_O(rresp),
    .GPIO_A_IN_I(p_in[0]), .GPIO_A_OUT_O(p_out[0]), .GPIO_A_OE_O(p_oe[0]),
    .GPIO_B_IN_I(p_in[1]), .GPIO_B_OUT_O(p_out[1]), .GPIO_B_OE_O(p_oe[1]),
    .GPIO_C_IN_I(p_in[2]), .GPIO_C_OUT_O(p_out[2]), .GPIO_C_OE_O(p_oe[2]));
  for (genvar g = 0; g < 3; g++)
  begin : g_pins
    gpb_pins_model i_pins (.out_i(p_out[g]), .oe_i(p_oe[g]),
      .ext_i(ext[g]), .pin_o(p_in[g]));
  end
  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    @(posedge clk);
    awv <= 1; wv <= 1; awa <= a; wd <= {24'h0000_00, d}; ws <= s; br <= 1;
    forever
    begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr_rdy) wv <= 0;
      if (bv && br) break;
    end
    br <= 0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
    @(posedge clk);
    arv <= 1; ara <= a; rr <= 1;
    forever
    begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv && rr) break;
    end
    rr <= 0;
    chk("rdata", rd_data, ed);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask : rd
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // Hang guard, far above the hundred or so cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] dv, dd;
    ext = '{8'hA5, 8'h3C, 8'h96};
    repeat (10) @(posedge clk);
    rst <= 0;
    for (int p = 0; p < 3; p++)
    begin
      chk("oe", p_oe[p], 32'h0000_0000);
      chk("out", p_out[p], 32'h0000_00FF);
      rd(IDX[p+3] << 2, 32'h0000_0000, `GPB_RESP_OKAY);
      rd(IDX[p] << 2, ext[p], `GPB_RESP_OKAY);
    end
    for (int p = 0; p < 3; p++)
    begin
      // Per-port values so a crossed decode shows up
      dv = 8'hF0 >> p;
      dd = 8'h5A + p[7:0];
      wr(IDX[p+3] << 2, dv, 4'h1, `GPB_RESP_OKAY);
      chk("oe", p_oe[p], dv);
      chk("out", p_out[p], 32'h0000_00FF);
      rd(IDX[p] << 2, dv | (ext[p] & ~dv), `GPB_RESP_OKAY);
      wr(IDX[p] << 2, dd, 4'h1, `GPB_RESP_OKAY);
      chk("out", p_out[p], dd);
      rd(IDX[p] << 2, (dd & dv) | (ext[p] & ~dv), `GPB_RESP_OKAY);
      wr(IDX[p] << 2, 8'h00, 4'h0, `GPB_RESP_OKAY);
      chk("out", p_out[p], dd);
      wr(IDX[p+3] << 2, ~dv, 4'h1, `GPB_RESP_OKAY);
      rd(IDX[p+3] << 2, 8'(~dv), `GPB_RESP_OKAY);
    end
    for (int p = 0; p < 3; p++)
    begin
      chk("oe", p_oe[p], 8'(~(8'hF0 >> p)));
      chk("out", p_out[p], 8'h5A + p[7:0]);
    end
    wr(32'hFFFF_C31C, 8'h77, 4'h1, `GPB_RESP_SLVERR);
    rd(32'hFFFF_C31C, 32'h0000_0000, `GPB_RESP_SLVERR);
    chk("oe", p_oe[2], 32'h0000_00C3);
    end_sim();
  end
endmodule : gpb_top_tb_top
